//--- hw/ecst_defs.vh
// constants for the extension context status tracker
`ifndef ECST_DEFS_VH
`define ECST_DEFS_VH
// ==========================================================
// status encoding
`define ECST_ST_OFF      2'h0
`define ECST_ST_INITIAL  2'h1
`define ECST_ST_CLEAN    2'h2
`define ECST_ST_DIRTY    2'h3
// ==========================================================
// instruction action codes on the retire port
`define ECST_ACT_NONE    3'h0
`define ECST_ACT_READ    3'h1
`define ECST_ACT_MODIFY  3'h2
`define ECST_ACT_UNCFG   3'h3
`define ECST_ACT_DISABLE 3'h4
`define ECST_ACT_ENABLE  3'h5
// ==========================================================
// register offsets
`define ECST_REG_STATUS  4'h0
`define ECST_REG_FPU     4'h1
`define ECST_REG_EXT0    4'h2
`define ECST_REG_EXT1    4'h3
`define ECST_REG_EXT2    4'h4
`define ECST_REG_EXT3    4'h5
`define ECST_REG_CFG     4'h6
// ==========================================================
// field positions in the summary status word
`define ECST_FS_LO       0
`define ECST_XS_LO       2
`define ECST_SD_BIT      7
// ==========================================================
// reset values and extension count
`define ECST_FPU_RST     2'h0
`define ECST_EXT_RST     2'h0
`define ECST_CFG_RST     2'h0
`define ECST_NUM_EXT     4
`endif

//--- hw/ecst_unit_fsm.v
// next-status logic for one tracked unit
`timescale 1ns/10ps
module ecst_unit_fsm (
  input  wire       fp_unit,
  input  wire [1:0] cur_st,
  input  wire [2:0] act,
  output reg  [1:0] nxt_st,
  output reg        fault
);
`include "ecst_defs.vh"
  // ========================================================
  // transition table for one retiring instruction
  always @* begin
    nxt_st = cur_st;
    fault  = 1'b0;
    case (act)
      `ECST_ACT_READ: begin
        if (cur_st == `ECST_ST_OFF) fault = 1'b1;
      end
      `ECST_ACT_MODIFY: begin
        if (cur_st == `ECST_ST_OFF) fault = 1'b1;
        else nxt_st = `ECST_ST_DIRTY;
      end
      `ECST_ACT_UNCFG: begin
        if (fp_unit || cur_st == `ECST_ST_OFF) fault = 1'b1;
        else nxt_st = `ECST_ST_INITIAL;
      end
      `ECST_ACT_DISABLE: begin
        if (fp_unit) fault = 1'b1;
        else nxt_st = `ECST_ST_OFF;
      end
      `ECST_ACT_ENABLE: begin
        if (fp_unit) fault = 1'b1;
        else nxt_st = `ECST_ST_INITIAL;
      end
      default: begin
        nxt_st = cur_st;
      end
    endcase
  end
endmodule

//--- hw/ecst_tracker.v
// extension context status tracker: fpu and extension status
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module ecst_tracker (
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire        has_fpu,
  input  wire        has_smode,
  input  wire        ret_valid,
  input  wire [2:0]  ret_unit,
  input  wire [2:0]  ret_act,
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  output reg         ret_fault,
  output reg         unit_init_req,
  output reg  [2:0]  unit_init_sel,
  output reg  [1:0]  fpu_context_status,
  output reg  [1:0]  extension_summary_status,
  output reg         dirty_summary_bit
);
`include "ecst_defs.vh"
  // ========================================================
  // straps pass two flops (pins from outside the domain)
  reg [1:0] fpu_sync_q;
  reg [1:0] smode_sync_q;
  always @(posedge mclk) begin
    if (sys_rst) begin
      fpu_sync_q   <= 2'h0;
      smode_sync_q <= 2'h0;
    end else begin
      fpu_sync_q   <= {fpu_sync_q[0], has_fpu};
      smode_sync_q <= {smode_sync_q[0], has_smode};
    end
  end
  // fpu status is forced to zero without fpu and without s-mode
  wire fs_live = fpu_sync_q[1] | smode_sync_q[1];

  // ========================================================
  // single shared status copies
  reg  [1:0] fs_q;
  reg  [1:0] xs_q [0:`ECST_NUM_EXT-1];
  reg  [3:0] ext_en_q;  // per-extension presence, all off at reset
  reg  [1:0] fs_d;
  reg  [1:0] xs_d [0:`ECST_NUM_EXT-1];

  // ========================================================
  // retire-side next state for the addressed unit
  wire       sel_fp = (ret_unit == 3'h0);
  wire [1:0] idx    = ret_unit[1:0] - 2'h1;
  wire       ext_ok = (ret_unit >= 3'h1) && (ret_unit <= 3'h4);
  wire [1:0] unit_cur;
  assign unit_cur = sel_fp ? (fs_live ? fs_q : `ECST_ST_OFF)
                  : (ext_ok && ext_en_q[idx]) ? xs_q[idx]
                  : `ECST_ST_OFF;
  wire [1:0] unit_nxt;
  wire       unit_fault;
  ecst_unit_fsm u_fsm (
    .fp_unit (sel_fp),
    .cur_st  (unit_cur),
    .act     (ret_act),
    .nxt_st  (unit_nxt),
    .fault   (unit_fault)
  );
  // a missing unit can only fault
  wire absent  = sel_fp ? ~fs_live : ~(ext_ok && ext_en_q[idx]);
  wire act_any = ret_valid && (ret_act != `ECST_ACT_NONE);
  wire do_upd  = act_any && !unit_fault && !absent;
  wire do_flt  = act_any && (unit_fault || absent);

  // ========================================================
  // register write decode
  wire wr_fs  = reg_wr && (reg_addr == `ECST_REG_FPU);
  wire wr_cfg = reg_wr && (reg_addr == `ECST_REG_CFG);

  // ========================================================
  // next fpu status: privileged write wins over retire update
  always @* begin
    fs_d = fs_q;
    if (!fs_live) begin
      fs_d = `ECST_ST_OFF;
    end else if (wr_fs) begin
      fs_d = reg_wdata[1:0];
    end else if (do_upd && sel_fp) begin
      fs_d = unit_nxt;
    end
  end

  // ========================================================
  // per-extension status registers and updates
  genvar g;
  generate
    for (g = 0; g < `ECST_NUM_EXT; g = g + 1) begin : g_ext
      wire wr_x = reg_wr && (reg_addr == (`ECST_REG_EXT0 + g));
      always @* begin
        xs_d[g] = xs_q[g];
        if (!ext_en_q[g]) begin
          xs_d[g] = `ECST_ST_OFF;
        end else if (wr_x) begin
          xs_d[g] = reg_wdata[1:0];
        end else if (do_upd && !sel_fp && idx == g) begin
          xs_d[g] = unit_nxt;
        end
      end
      always @(posedge mclk) begin
        if (sys_rst) begin
          xs_q[g] <= `ECST_EXT_RST;
        end else begin
          xs_q[g] <= xs_d[g];
        end
      end
    end
  endgenerate

  // ========================================================
  // summary: maximum across extensions
  reg [1:0] xs_max;
  integer   k;
  always @* begin
    xs_max = `ECST_ST_OFF;
    for (k = 0; k < `ECST_NUM_EXT; k = k + 1) begin
      if (xs_q[k] > xs_max) xs_max = xs_q[k];
    end
  end
  wire [1:0] fs_vis = fs_live ? fs_q : `ECST_ST_OFF;
  wire sd_now = (fs_vis == `ECST_ST_DIRTY) ||
                (xs_max == `ECST_ST_DIRTY);

  // ========================================================
  // state flops, fault and init request outputs
  always @(posedge mclk) begin
    if (sys_rst) begin
      fs_q          <= `ECST_FPU_RST;
      ext_en_q      <= 4'h0;
      ret_fault     <= 1'b0;
      unit_init_req <= 1'b0;
      unit_init_sel <= 3'h0;
    end else begin
      fs_q          <= fs_d;
      if (wr_cfg) ext_en_q <= reg_wdata[3:0];
      ret_fault     <= do_flt;
      // enable must leave the unit state at its constant value
      unit_init_req <= do_upd && (ret_act == `ECST_ACT_ENABLE);
      unit_init_sel <= ret_unit;
    end
  end

  // ========================================================
  // registered status outputs
  always @(posedge mclk) begin
    if (sys_rst) begin
      fpu_context_status       <= `ECST_ST_OFF;
      extension_summary_status <= `ECST_ST_OFF;
      dirty_summary_bit        <= 1'b0;
    end else begin
      fpu_context_status       <= fs_vis;
      extension_summary_status <= xs_max;
      dirty_summary_bit        <= sd_now;
    end
  end

  // ========================================================
  // register read port, data one cycle after the strobe
  always @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      if (reg_addr == `ECST_REG_STATUS) begin
        reg_rdata <= {24'h00_0000, sd_now, 3'h0, xs_max, fs_vis};
      end else if (reg_addr == `ECST_REG_FPU) begin
        reg_rdata <= {30'h0000_0000, fs_vis};
      end else if (reg_addr >= `ECST_REG_EXT0 &&
                   reg_addr <= `ECST_REG_EXT3) begin
        reg_rdata <= {30'h0000_0000, xs_q[reg_addr[1:0] - 2'h2]};
      end else if (reg_addr == `ECST_REG_CFG) begin
        reg_rdata <= {28'h000_0000, ext_en_q};
      end else begin
        reg_rdata <= 32'h0000_0000;  // unmapped reads zero
      end
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule

//--- tb/ecst_tracker_props.sv
// assertion checker for the context status tracker
`timescale 1ns/10ps
`include "ecst_defs.vh"
module ecst_tracker_props (
  input logic        mclk,
  input logic        sys_rst,
  input logic        has_fpu,
  input logic        has_smode,
  input logic        ret_valid,
  input logic [2:0]  ret_unit,
  input logic [2:0]  ret_act,
  input logic [3:0]  reg_addr,
  input logic [31:0] reg_wdata,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [31:0] reg_rdata,
  input logic        ret_fault,
  input logic        unit_init_req,
  input logic [2:0]  unit_init_sel,
  input logic [1:0]  fpu_context_status,
  input logic [1:0]  extension_summary_status,
  input logic        dirty_summary_bit
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // status and fault relations
  chk_sd_summary: assert property (
    dirty_summary_bit == (fpu_context_status == `ECST_ST_DIRTY ||
    extension_summary_status == `ECST_ST_DIRTY))
    else $error("dirty summary wrong");
  chk_fault_cause: assert property (
    ret_fault |-> $past(ret_valid) && $past(ret_act) != `ECST_ACT_NONE)
    else $error("fault without retire");
  chk_fault_excl: assert property (
    !(ret_fault && unit_init_req)) else $error("fault with init");
  chk_init_cause: assert property (
    unit_init_req |-> $past(ret_act) == `ECST_ACT_ENABLE &&
    $past(ret_unit) == unit_init_sel) else $error("bad init request");
  chk_fpu_bad_act: assert property (
    ret_valid && ret_unit == 3'h0 && ret_act inside {`ECST_ACT_UNCFG,
    `ECST_ACT_DISABLE, `ECST_ACT_ENABLE} |=> ret_fault)
    else $error("fpu action not refused");
  chk_fpu_mod_dirty: assert property (
    ret_valid && ret_unit == 3'h0 && ret_act == `ECST_ACT_MODIFY &&
    !reg_wr ##1 !ret_fault |=> fpu_context_status == `ECST_ST_DIRTY)
    else $error("modify did not dirty");
  chk_fpu_read_keep: assert property (
    ret_valid && ret_unit == 3'h0 && ret_act == `ECST_ACT_READ &&
    !reg_wr |-> ##2 $stable(fpu_context_status))
    else $error("read changed status");
  chk_fault_keeps: assert property (
    ret_fault && $past(ret_unit) == 3'h0 && !$past(reg_wr)
    |=> $stable(fpu_context_status)) else $error("fault changed status");
endmodule
bind ecst_tracker ecst_tracker_props i_chk (.*);

//--- tb/ecst_sw_model.sv
// pipeline and privileged software model driving the tracker
`timescale 1ns/10ps
`include "ecst_defs.vh"
module ecst_sw_model (
  input  logic        mclk,
  input  logic [31:0] reg_rdata,
  input  logic        ret_fault,
  output logic        ret_valid,
  output logic [2:0]  ret_unit,
  output logic [2:0]  ret_act,
  output logic [3:0]  reg_addr,
  output logic [31:0] reg_wdata,
  output logic        reg_wr,
  output logic        reg_rd
);
  initial {ret_valid, ret_unit, ret_act, reg_addr, reg_wr, reg_rd} = '0;
  initial reg_wdata = '0;
  // one retire pulse, fault sampled in the following cycle
  task automatic retire(input logic [2:0] u, a, output logic f);
    @(posedge mclk);
    ret_valid <= 1'b1;
    ret_unit  <= u;
    ret_act   <= a;
    @(posedge mclk);
    ret_valid <= 1'b0;
    ret_act   <= `ECST_ACT_NONE;
    #1 f = ret_fault;
  endtask
  // one-cycle write; data scrambled once released
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~v;
  endtask
  // one-cycle read, data taken in the next cycle
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // context save: store only dirty state, then mark it clean
  task automatic ctx_save;
    logic [31:0] v;
    rd(`ECST_REG_FPU, v);
    if (v[1:0] == `ECST_ST_DIRTY) wr(`ECST_REG_FPU, 32'h0000_0002);
  endtask
  // context restore: off untouched, initial without memory, never dirty
  task automatic ctx_restore(input logic [1:0] saved);
    if (saved == `ECST_ST_INITIAL) begin
      wr(`ECST_REG_FPU, 32'h0000_0001); // state zeroed
    end else if (saved != `ECST_ST_OFF) begin
      wr(`ECST_REG_FPU, 32'h0000_0002); // loaded, clean
    end
  endtask
endmodule

//--- tb/ecst_tracker_bench.sv
// self-checking bench for the context status tracker
`timescale 1ns/10ps
`include "ecst_defs.vh"
module ecst_tracker_bench;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        has_fpu = 1'b1;
  logic        has_smode = 1'b0;
  logic        ret_valid, reg_wr, reg_rd, ret_fault, f;
  logic        unit_init_req, dirty_summary_bit;
  logic [2:0]  ret_unit, ret_act, unit_init_sel;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [1:0]  fpu_context_status, extension_summary_status;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cycles = 0;
  ecst_tracker  i_dut (.*);
  ecst_sw_model i_sw (.*);
  always #4 mclk = ~mclk;
  // hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      stop_test;
    end
  end
  task automatic chk(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // status outputs are registered one cycle behind the state
  task automatic settle;
    @(posedge mclk);
    #1;
  endtask
  // summary word read: sd at 7, xs at 3:2, fs at 1:0
  task automatic st(input logic [1:0] fs, xs, input logic sd);
    i_sw.rd(`ECST_REG_STATUS, d);
    chk(d, {24'h0, sd, 3'h0, xs, fs});
  endtask
  // ==========================================================
  // floating-point status sequence
  task automatic t_fpu;
    i_sw.retire(3'h0, `ECST_ACT_READ, f);
    chk(f, 1);
    i_sw.wr(`ECST_REG_FPU, 32'h0000_0001);
    st(2'h1, 2'h0, 1'b0);
    i_sw.retire(3'h0, `ECST_ACT_READ, f);
    chk({f, fpu_context_status}, 3'h1);
    i_sw.retire(3'h0, `ECST_ACT_MODIFY, f);
    settle;
    chk({f, dirty_summary_bit, fpu_context_status}, 4'h7);
    for (int a = 3; a <= 5; a++) begin
      i_sw.retire(3'h0, 3'(a), f);
      chk({f, fpu_context_status}, 3'h7);
    end
    i_sw.ctx_save();
    st(2'h2, 2'h0, 1'b0);
    i_sw.wr(`ECST_REG_STATUS, 32'h0000_00ff);
    st(2'h2, 2'h0, 1'b0);
    i_sw.ctx_restore(`ECST_ST_INITIAL);
    st(2'h1, 2'h0, 1'b0);
    i_sw.ctx_restore(`ECST_ST_DIRTY);
    st(2'h2, 2'h0, 1'b0);
  endtask
  // ==========================================================
  // extension status sequence
  task automatic t_ext;
    i_sw.wr(`ECST_REG_CFG, 32'h0000_000f);
    i_sw.retire(3'h1, `ECST_ACT_ENABLE, f);
    chk({f, unit_init_req, unit_init_sel}, 5'h09);
    i_sw.retire(3'h1, `ECST_ACT_MODIFY, f);
    settle;
    chk({f, dirty_summary_bit, extension_summary_status}, 4'h7);
    i_sw.wr(`ECST_REG_EXT2, 32'h0000_0002);
    i_sw.retire(3'h1, `ECST_ACT_UNCFG, f);
    st(2'h2, 2'h2, 1'b0);
    i_sw.rd(`ECST_REG_EXT0, d);
    chk(d, 32'h0000_0001);
    i_sw.retire(3'h1, `ECST_ACT_DISABLE, f);
    i_sw.retire(3'h1, `ECST_ACT_READ, f);
    chk(f, 1);
    i_sw.rd(`ECST_REG_EXT0, d);
    chk(d, 32'h0000_0000);
    i_sw.retire(3'h7, `ECST_ACT_READ, f);
    chk(f, 1);
    i_sw.rd(4'hf, d);
    chk(d, 32'h0000_0000);
  endtask
  task automatic stop_test;
    if (miscompares == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge mclk);
    t_fpu;
    t_ext;
    stop_test;
  end
endmodule
